// ---- ocr_chk.sv ----
// Port-level assertions for the oscillator control register block.
`timescale 1ns/10ps
module ocr_chk #(
  parameter int DELAY_CYCLES = ocr_pkg::STEER_DELAY_CYC
) (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        sw_gate_strap,
  input wire logic                        oe_pin,
  input wire logic                        host_byte_valid,
  input wire logic                        host_rd_req,
  input wire logic [7:0]                  host_rd_addr,
  input wire logic [15:0]                 host_rd_data,
  input wire logic                        host_rd_valid,
  input wire logic [ocr_pkg::OFFSET_W-1:0] freq_offset,
  input wire logic [ocr_pkg::PULL_SPAN_W-1:0] pull_span,
  input wire logic [ocr_pkg::FB_INT_W-1:0] fb_int,
  input wire logic [ocr_pkg::FB_FRAC_W-1:0] fb_frac,
  input wire logic                        steer_pending,
  input wire logic                        steer_moving,
  input wire logic                        out_enable
);
  import ocr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Phase lengths are counted here because they exceed any repetition.
  int          pcnt_reg;
  int          mcnt_reg;
  logic [15:0] fb_word;

  // Read-back is taken from the state of the request cycle.
  assign fb_word = {fb_int, fb_frac[26:16]};
  always_ff @(posedge ref_clk) begin
    pcnt_reg <= (rst || !steer_pending) ? 0 : pcnt_reg + 1;
    mcnt_reg <= (rst || !steer_moving) ? 0 : mcnt_reg + 1;
  end

  sequence delay_end_s;
    $fell(steer_pending);
  endsequence
  // A restart during settling raises pending; only a clean end is timed.
  sequence settle_end_s;
    $fell(steer_moving) ##0 !steer_pending ##1 !steer_pending;
  endsequence

  rd_answer_a : assert property (
    host_rd_req |=> host_rd_valid) else $error("read not answered");
  unmapped_zero_a : assert property (
    host_rd_req && host_rd_addr > 8'h06 |=> host_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  span_read_a : assert property (
    host_rd_req && host_rd_addr == 8'h02
    |=> host_rd_data == {12'h000, $past(pull_span)})
    else $error("pull span readback wrong");
  fb_read_a : assert property (
    host_rd_req && host_rd_addr == 8'h03
    |=> host_rd_data == $past(fb_word))
    else $error("feedback readback wrong");
  sw_gate_a : assert property (
    sw_gate_strap && !host_byte_valid |=> $stable(out_enable))
    else $error("enable moved without a write");
  pin_gate_a : assert property (
    (!sw_gate_strap && $stable(oe_pin)) [*8] |-> out_enable == oe_pin)
    else $error("enable does not follow pin");
  offset_apply_a : assert property (
    $changed(freq_offset) |-> delay_end_s)
    else $error("offset changed outside apply");
  move_start_a : assert property (
    delay_end_s |-> steer_moving) else $error("movement did not start");
  delay_len_a : assert property (
    delay_end_s |-> pcnt_reg == DELAY_CYCLES || pcnt_reg == DELAY_CYCLES + 1)
    else $error("delay length wrong");
  settle_len_a : assert property (
    settle_end_s |-> $past(mcnt_reg) == STEER_SETTLE_CYC)
    else $error("settle length wrong");
endmodule

// ---- ocr_control_regs.sv ----
// Control register file, frequency steering sequencer and output gating.
`timescale 1ns/10ps

//
// Function
// - A multi-byte write fills consecutive registers, the address stepping after each completed register.
// - Frequency movement starts a fixed delay after the upper offset register is written.
// - After movement starts the output is reported settled after a fixed settling interval.
// - In software gating mode the driver follows the output-enable bit of the upper-word register.
// - In software gating mode the output starts disabled until the host writes the enable bit.
// - In pin gating mode writes to the output-enable bit are ignored.
// - Software gating exists only when the factory option selects it; otherwise the pin governs.
// - The lower offset register holds offset bits 15 to 0, fully read and write.
// - The upper register holds offset bits 25 to 16 in its low ten bits, bits 15 to 11 read-only.
// - The pull span register holds a four-bit selector with the upper bits read-only.
// - The feedback register holds the integer part in bits 15 to 11 and upper fraction below.
// - The feedback low register holds the lower sixteen fraction bits, fully read and write.
// - A frequency change is launched only by a write to the upper offset register.
// - The offset word is 26-bit two's complement and resets to zero.
// - Unused read-only bits read as zero and ignore writes.
module ocr_control_regs
  import ocr_pkg::*;
#(
  parameter int DELAY_CYCLES = ocr_pkg::STEER_DELAY_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          sw_gate_strap,
  input  wire logic                          oe_pin,
  input  wire logic                          host_start,
  input  wire logic [7:0]                    host_addr,
  input  wire logic                          host_byte_valid,
  input  wire logic [7:0]                    host_byte,
  input  wire logic                          host_stop,
  input  wire logic                          host_rd_req,
  input  wire logic [7:0]                    host_rd_addr,
  output logic [15:0]                        host_rd_data,
  output logic                               host_rd_valid,
  output logic [ocr_pkg::OFFSET_W-1:0]       freq_offset,
  output logic [ocr_pkg::PULL_SPAN_W-1:0]    pull_span,
  output logic [ocr_pkg::FB_INT_W-1:0]       fb_int,
  output logic [ocr_pkg::FB_FRAC_W-1:0]      fb_frac,
  output logic [ocr_pkg::FWD_DIV_W-1:0]      fwd_div,
  output logic [ocr_pkg::DRV_CTRL_W-1:0]     drv_ctrl,
  output logic [ocr_pkg::DRV_SET_W-1:0]      drv_setting,
  output logic                               steer_pending,
  output logic                               steer_moving,
  output logic                               out_enable
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  localparam logic [TIMER_W-1:0] DELAY_LOAD  = TIMER_W'(DELAY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SETTLE_LOAD = TIMER_W'(STEER_SETTLE_CYC - 1);

  ocr_state_s  st_reg;
  ocr_state_s  st_next;
  logic        pin_level;
  logic        delay_start;
  logic        delay_done;
  logic        settle_start;
  logic        settle_done;
  logic [15:0] word;
  logic        word_done;

  // -----------------------------------------------------------------------
  // Support blocks
  // -----------------------------------------------------------------------
  ocr_pin_sync u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (oe_pin),
    .level   (pin_level)
  );

  ocr_countdown #(
    .WIDTH (TIMER_W)
  ) u_delay (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (delay_start),
    .load    (DELAY_LOAD),
    .busy    (),
    .done    (delay_done)
  );

  ocr_countdown #(
    .WIDTH (TIMER_W)
  ) u_settle (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (settle_start),
    .load    (SETTLE_LOAD),
    .busy    (),
    .done    (settle_done)
  );

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    delay_start  = 1'b0;
    settle_start = 1'b0;
    word         = {st_reg.first_byte, host_byte};
    word_done    = 1'b0;
    st_next.rd_valid = 1'b0;

    // Byte assembly: high byte first, then low byte completes a register.
    if (host_start) begin
      st_next.in_txn    = 1'b1;
      st_next.addr      = host_addr;
      st_next.have_byte = 1'b0;
    end else if (host_stop) begin
      // A lone high byte at the end of a transfer is dropped.
      st_next.in_txn    = 1'b0;
      st_next.have_byte = 1'b0;
    end else if (host_byte_valid && st_reg.in_txn) begin
      if (!st_reg.have_byte) begin
        st_next.first_byte = host_byte;
        st_next.have_byte  = 1'b1;
      end else begin
        word_done         = 1'b1;
        st_next.have_byte = 1'b0;
        st_next.addr      = st_reg.addr + 8'h01;
      end
    end

    if (word_done) begin
      case (st_reg.addr)
        ADDR_FREQ_OFFSET_LOW: begin
          st_next.low_word = word;
        end
        ADDR_GATE_AND_FREQ_OFFSET_HIGH: begin
          st_next.high_word = word[HIGH_WORD_W-1:0];
          if (st_reg.sw_mode) begin
            st_next.oe_sw = word[OE_BIT];
          end
          // The word is taken whole so a later lower write cannot tear it.
          st_next.pending = {word[HIGH_WORD_W-1:0], st_reg.low_word};
          delay_start     = 1'b1;
        end
        ADDR_PULL_SPAN_SELECT: begin
          st_next.pull_span = word[PULL_SPAN_W-1:0];
        end
        ADDR_FEEDBACK_DIV_INT_FRAC_HIGH: begin
          st_next.fb_high = word;
        end
        ADDR_FEEDBACK_DIV_FRAC_LOW: begin
          st_next.fb_low = word;
        end
        ADDR_FORWARD_DIV_AND_DRIVER: begin
          st_next.fwd_drv = word;
        end
        ADDR_DRIVER_DIV_AND_SETTING: begin
          st_next.drv_set = word[DRV_SET_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Steering sequence; a fresh upper write restarts it from the delay.
    case (st_reg.steer)
      STEER_IDLE: begin
        if (delay_start) begin
          st_next.steer = STEER_DELAY;
        end
      end
      STEER_DELAY: begin
        if (delay_start) begin
          st_next.steer = STEER_DELAY;
        end else if (delay_done) begin
          st_next.applied = st_reg.pending;
          st_next.steer   = STEER_SETTLE;
          settle_start    = 1'b1;
        end
      end
      STEER_SETTLE: begin
        if (delay_start) begin
          st_next.steer = STEER_DELAY;
        end else if (settle_done) begin
          st_next.steer = STEER_IDLE;
        end
      end
      default: begin
        st_next.steer = STEER_IDLE;
      end
    endcase

    // Output gating follows the bit or the filtered pin by factory option.
    if (st_reg.sw_mode) begin
      st_next.oe_out = st_next.oe_sw;
    end else begin
      st_next.oe_out = pin_level;
    end

    // Register read-back; reserved and unmapped bits return zero.
    if (host_rd_req) begin
      st_next.rd_valid = 1'b1;
      case (host_rd_addr)
        ADDR_FREQ_OFFSET_LOW: begin
          st_next.rd_data = st_reg.low_word;
        end
        ADDR_GATE_AND_FREQ_OFFSET_HIGH: begin
          st_next.rd_data = {5'h00, st_reg.oe_sw, st_reg.high_word};
        end
        ADDR_PULL_SPAN_SELECT: begin
          st_next.rd_data = {12'h000, st_reg.pull_span};
        end
        ADDR_FEEDBACK_DIV_INT_FRAC_HIGH: begin
          st_next.rd_data = st_reg.fb_high;
        end
        ADDR_FEEDBACK_DIV_FRAC_LOW: begin
          st_next.rd_data = st_reg.fb_low;
        end
        ADDR_FORWARD_DIV_AND_DRIVER: begin
          st_next.rd_data = st_reg.fwd_drv;
        end
        ADDR_DRIVER_DIV_AND_SETTING: begin
          st_next.rd_data = {12'h000, st_reg.drv_set};
        end
        default: begin
          st_next.rd_data = 16'h0000;
        end
      endcase
    end

    // The gating option is a strap held steady through reset.
    if (rst) begin
      st_next            = '0;
      st_next.low_word   = RST_FREQ_OFFSET_LOW;
      st_next.high_word  = RST_FREQ_OFFSET_HIGH;
      st_next.oe_sw      = RST_OE_SW;
      st_next.pull_span  = RST_PULL_SPAN;
      st_next.fb_high    = RST_FB_HIGH;
      st_next.fb_low     = RST_FB_LOW;
      st_next.fwd_drv    = RST_FWD_DRV;
      st_next.drv_set    = RST_DRV_SET;
      st_next.steer      = STEER_IDLE;
      st_next.sw_mode    = sw_gate_strap;
      st_next.oe_out     = 1'b0;
      delay_start        = 1'b0;
      settle_start       = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign host_rd_data  = st_reg.rd_data;
  assign host_rd_valid = st_reg.rd_valid;
  assign freq_offset   = st_reg.applied;
  assign pull_span     = st_reg.pull_span;
  assign fb_int        = st_reg.fb_high[REG_W-1:FB_INT_LSB];
  assign fb_frac       = {st_reg.fb_high[FB_FRAC_HIGH_W-1:0], st_reg.fb_low};
  assign fwd_div       = st_reg.fwd_drv[REG_W-1:FWD_DIV_LSB];
  assign drv_ctrl      = st_reg.fwd_drv[DRV_CTRL_W-1:0];
  assign drv_setting   = st_reg.drv_set;
  assign steer_pending = (st_reg.steer == STEER_DELAY);
  assign steer_moving  = (st_reg.steer == STEER_SETTLE);
  assign out_enable    = st_reg.oe_out;

endmodule

// ---- ocr_control_regs_tb_top.sv ----
// Self-checking bench for the oscillator control register block.
`timescale 1ns/10ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    err_total++; \
    $display("wrong value at %0t got %h expected %h", $time, a, e); \
  end \
end
module ocr_control_regs_tb_top;
  import ocr_pkg::*;
  localparam int DLY = 20;
  localparam logic [15:0] EXP_RD [6] = '{16'h000f, 16'ha5c3, 16'h9876,
                                          16'h1239, 16'h000d, 16'h0000};
  logic        ref_clk, rst, sw_gate_strap, oe_pin, host_start;
  logic        host_byte_valid, host_stop, host_rd_req, host_rd_valid;
  logic        steer_pending, steer_moving, out_enable;
  logic [7:0]  host_addr, host_byte, host_rd_addr;
  logic [15:0] host_rd_data, d;
  logic [25:0] freq_offset;
  logic [3:0]  pull_span, drv_setting;
  logic [4:0]  fb_int;
  logic [26:0] fb_frac;
  logic [12:0] fwd_div;
  logic [2:0]  drv_ctrl;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          k;

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // The ceiling allows two full steering cycles plus all register traffic.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    rst <= 1'b1;
    sw_gate_strap <= strap;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
  endtask

  task automatic wait_move(input logic [25:0] old_w, new_w);
    #1;
    `CHK(steer_pending, 1'b1)
    `CHK(freq_offset, old_w)
    for (k = 0; k < DLY + 4 && steer_moving !== 1'b1; k++)
      @(posedge ref_clk);
    #1;
    `CHK(freq_offset, new_w)
  endtask

  task automatic wait_still();
    for (k = 0; k < 3400 && steer_moving !== 1'b0; k++)
      @(posedge ref_clk);
    #1;
    `CHK(steer_moving, 1'b0)
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sw_gate_strap = 1'b1;
    oe_pin = 1'b0;
    do_reset(1'b1);
    for (int a = 0; a < 7; a++) begin
      i_ocr_host_model.rd(8'(a), d);
      `CHK(d, 16'h0000)
    end
    `CHK(out_enable, 1'b0)
    `CHK(freq_offset, 26'h0)
    i_ocr_host_model.wr(8'h00, '{16'h1234, 16'hfeaa}, 1'b0);
    wait_move(26'h0, {10'h2aa, 16'h1234});
    `CHK(out_enable, 1'b1)
    i_ocr_host_model.rd(8'h01, d);
    `CHK(d, 16'h06aa)
    i_ocr_host_model.rd(8'h00, d);
    `CHK(d, 16'h1234)
    i_ocr_host_model.wr(8'h01, '{16'h0155}, 1'b0);
    wait_move({10'h2aa, 16'h1234}, {10'h155, 16'h1234});
    `CHK(out_enable, 1'b0)
    wait_still();
    i_ocr_host_model.wr(8'h00, '{16'h5555}, 1'b0);
    repeat (DLY + 4) @(posedge ref_clk);
    #1;
    `CHK(steer_pending, 1'b0)
    `CHK(freq_offset, {10'h155, 16'h1234})
    i_ocr_host_model.wr(8'h02, '{16'hffff, 16'ha5c3, 16'h9876,
                                 16'h1239, 16'hfffd}, 1'b1);
    #1;
    `CHK(fb_int, 5'h14)
    `CHK(fb_frac, {11'h5c3, 16'h9876})
    `CHK(pull_span, 4'hf)
    `CHK(fwd_div, 13'h0247)
    `CHK(drv_ctrl, 3'h1)
    `CHK(drv_setting, 4'hd)
    for (int a = 0; a < 6; a++) begin
      i_ocr_host_model.rd(8'(a + 2), d);
      `CHK(d, EXP_RD[a])
    end
    oe_pin <= 1'b1;
    do_reset(1'b0);
    #1;
    `CHK(freq_offset, 26'h0)
    i_ocr_host_model.wr(8'h01, '{16'h0000}, 1'b0);
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK(out_enable, 1'b1)
    i_ocr_host_model.wr(8'h01, '{16'h0400}, 1'b0);
    i_ocr_host_model.rd(8'h01, d);
    `CHK(d, 16'h0000)
    oe_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK(out_enable, 1'b0)
    complete_run();
  end

  ocr_control_regs #(.DELAY_CYCLES(DLY)) i_ocr_control_regs (
    .ref_clk, .rst, .sw_gate_strap, .oe_pin, .host_start, .host_addr,
    .host_byte_valid, .host_byte, .host_stop, .host_rd_req, .host_rd_addr,
    .host_rd_data, .host_rd_valid, .freq_offset, .pull_span, .fb_int,
    .fb_frac, .fwd_div, .drv_ctrl, .drv_setting, .steer_pending,
    .steer_moving, .out_enable
  );

  ocr_host_model i_ocr_host_model (
    .ref_clk, .host_rd_data, .host_rd_valid, .host_start, .host_addr,
    .host_byte_valid, .host_byte, .host_stop, .host_rd_req, .host_rd_addr
  );
endmodule

bind ocr_control_regs ocr_chk #(.DELAY_CYCLES(DELAY_CYCLES)) i_ocr_chk (
  .ref_clk, .rst, .sw_gate_strap, .oe_pin, .host_byte_valid, .host_rd_req,
  .host_rd_addr, .host_rd_data, .host_rd_valid, .freq_offset, .pull_span,
  .fb_int, .fb_frac, .steer_pending, .steer_moving, .out_enable
);

// ---- ocr_countdown.sv ----
// Restartable countdown timer that pulses when its interval has elapsed.
`timescale 1ns/10ps
module ocr_countdown #(
  parameter int WIDTH = 15
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  output logic                  busy,
  output logic                  done
);

  typedef struct packed {
    logic             run;
    logic [WIDTH-1:0] cnt;
  } ocr_timer_s;

  ocr_timer_s tmr_reg;
  ocr_timer_s tmr_next;

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  // A start while running restarts the interval from the full load value.
  always_comb begin
    tmr_next = tmr_reg;
    if (start) begin
      tmr_next.run = 1'b1;
      tmr_next.cnt = load;
    end else if (tmr_reg.run) begin
      if (tmr_reg.cnt == '0) begin
        tmr_next.run = 1'b0;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - 1'b1;
      end
    end
    if (rst) begin
      tmr_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    tmr_reg <= tmr_next;
  end

  assign busy = tmr_reg.run;
  assign done = tmr_reg.run && (tmr_reg.cnt == '0) && !start;

endmodule

// ---- ocr_host_model.sv ----
// Behavioural host driving the byte-level write and word read ports.
`timescale 1ns/10ps
module ocr_host_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] host_rd_data,
  input  wire logic        host_rd_valid,
  output logic             host_start,
  output logic [7:0]       host_addr,
  output logic             host_byte_valid,
  output logic [7:0]       host_byte,
  output logic             host_stop,
  output logic             host_rd_req,
  output logic [7:0]       host_rd_addr
);
  initial begin
    host_start = 1'b0;
    host_addr = 8'h00;
    host_byte_valid = 1'b0;
    host_byte = 8'h00;
    host_stop = 1'b0;
    host_rd_req = 1'b0;
    host_rd_addr = 8'h00;
  end

  // Idle address and byte buses show inverted values so a stale byte is never reused.
  task automatic wr(input logic [7:0] a, input logic [15:0] w[$],
                    input bit odd);
    @(posedge ref_clk);
    host_start <= 1'b1;
    host_addr <= a;
    foreach (w[i]) begin
      @(posedge ref_clk);
      host_start <= 1'b0;
      host_addr <= ~a;
      host_byte_valid <= 1'b1;
      host_byte <= w[i][15:8];
      @(posedge ref_clk);
      host_byte <= w[i][7:0];
    end
    if (odd) begin
      @(posedge ref_clk);
      host_byte <= 8'h77;
    end
    @(posedge ref_clk);
    host_byte_valid <= 1'b0;
    host_byte <= ~host_byte;
    host_stop <= 1'b1;
    @(posedge ref_clk);
    host_stop <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    host_rd_req <= 1'b1;
    host_rd_addr <= a;
    @(posedge ref_clk);
    host_rd_req <= 1'b0;
    host_rd_addr <= ~a;
    @(posedge ref_clk);
    d = (host_rd_valid === 1'b1) ? host_rd_data : 16'hdead;
  endtask
endmodule

// ---- ocr_pin_sync.sv ----
// Three-stage synchroniser with agreement filter for the enable pin.
`timescale 1ns/10ps
module ocr_pin_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ocr_sync_s;

  ocr_sync_s sync_reg;
  ocr_sync_s sync_next;

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  // The first stage only feeds the second, so a metastable value never
  // reaches the agreement compare.
  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    if (sync_reg.s2 == sync_reg.s3) begin
      sync_next.lvl = sync_reg.s3;
    end
    if (rst) begin
      sync_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    sync_reg <= sync_next;
  end

  assign level = sync_reg.lvl;

endmodule

// ---- ocr_pkg.sv ----
// Constants, register map and state types for the oscillator control block.
package ocr_pkg;

  // ---------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_FREQ_OFFSET_LOW           = 8'h00;
  localparam logic [7:0] ADDR_GATE_AND_FREQ_OFFSET_HIGH = 8'h01;
  localparam logic [7:0] ADDR_PULL_SPAN_SELECT          = 8'h02;
  localparam logic [7:0] ADDR_FEEDBACK_DIV_INT_FRAC_HIGH = 8'h03;
  localparam logic [7:0] ADDR_FEEDBACK_DIV_FRAC_LOW     = 8'h04;
  localparam logic [7:0] ADDR_FORWARD_DIV_AND_DRIVER    = 8'h05;
  localparam logic [7:0] ADDR_DRIVER_DIV_AND_SETTING    = 8'h06;

  // ---------------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------------
  localparam int REG_W          = 16;
  localparam int OFFSET_W       = 26;
  localparam int HIGH_WORD_W    = 10;
  localparam int OE_BIT         = 10;
  localparam int PULL_SPAN_W    = 4;
  localparam int FB_INT_LSB     = 11;
  localparam int FB_INT_W       = 5;
  localparam int FB_FRAC_HIGH_W = 11;
  localparam int FB_FRAC_W      = 27;
  localparam int FWD_DIV_LSB    = 3;
  localparam int FWD_DIV_W      = 13;
  localparam int DRV_CTRL_W     = 3;
  localparam int DRV_DIV_BIT    = 3;
  localparam int DRV_SET_W      = 4;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] RST_FREQ_OFFSET_LOW  = 16'h0000;
  localparam logic [9:0]  RST_FREQ_OFFSET_HIGH = 10'h000;
  localparam logic        RST_OE_SW            = 1'b0;
  localparam logic [3:0]  RST_PULL_SPAN        = 4'h0;
  localparam logic [15:0] RST_FB_HIGH          = 16'h0000;
  localparam logic [15:0] RST_FB_LOW           = 16'h0000;
  localparam logic [15:0] RST_FWD_DRV          = 16'h0000;
  localparam logic [3:0]  RST_DRV_SET          = 4'h0;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 5;
  localparam int STEER_DELAY_NS    = 103000;
  localparam int STEER_SETTLE_NS   = 16500;
  localparam int STEER_DELAY_CYC   = STEER_DELAY_NS / CLK_PERIOD_NS;
  localparam int STEER_SETTLE_CYC  = STEER_SETTLE_NS / CLK_PERIOD_NS;
  localparam int TIMER_W           = 15;

  // ---------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    STEER_IDLE   = 2'b00,
    STEER_DELAY  = 2'b01,
    STEER_SETTLE = 2'b10
  } ocr_steer_e;

  typedef struct packed {
    logic [15:0] low_word;
    logic [9:0]  high_word;
    logic        oe_sw;
    logic [3:0]  pull_span;
    logic [15:0] fb_high;
    logic [15:0] fb_low;
    logic [15:0] fwd_drv;
    logic [3:0]  drv_set;
    logic        in_txn;
    logic [7:0]  addr;
    logic        have_byte;
    logic [7:0]  first_byte;
    logic [25:0] pending;
    logic [25:0] applied;
    ocr_steer_e  steer;
    logic        sw_mode;
    logic        oe_out;
    logic [15:0] rd_data;
    logic        rd_valid;
  } ocr_state_s;

endpackage
